//--- usbdc_pkg.sv
package usbdc_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_IEN_WR = 8'hC2;
    localparam logic [7:0] CMD_IEN_RD = 8'hC3;
    localparam logic [7:0] CMD_CFG_WR = 8'hF0;
    localparam logic [7:0] CMD_CFG_RD = 8'hF1;
    localparam logic [7:0] CMD_CNT_WR = 8'hF2;
    localparam logic [7:0] CMD_CNT_RD = 8'hF3;
    localparam logic [7:0] CMD_SOFT_RST = 8'hF6;
    // ------------------------------------------------------------
    // dma_setup field positions
    // ------------------------------------------------------------
    localparam int BIT_COUNT_ZERO_END = 15;
    localparam int BIT_SHORT_END_MODE = 14;
    localparam int EP_SEL_LSB = 4;
    localparam int BIT_DMA_RUN = 3;
    localparam int BURST_LSB = 0;
    // ------------------------------------------------------------
    // irq_enable_mask event positions
    // ------------------------------------------------------------
    localparam int EV_BUS_RESET = 0;
    localparam int EV_RESUME = 1;
    localparam int EV_SUSPEND = 2;
    localparam int EV_TEND = 3;
    localparam int EV_FRAME = 4;
    localparam int EV_PSEUDO = 5;
    localparam int EV_SHORT = 6;
    localparam int EV_EP_LSB = 8;
    localparam int EV_W = 24;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] IEN_RST = 32'h0000_0000;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    // cs_n, rd_n and wr_n idle high; data and a0 low
    localparam logic [19:0] PIN_IDLE = 20'h70000;
    // ------------------------------------------------------------
    // timing and sizes
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int IRQ_PULSE_NS = 166;
    localparam int IRQ_PULSE_FLOOR = IRQ_PULSE_NS / CLK_PERIOD_NS;
    localparam logic [2:0] IRQ_PULSE_CYC =
        3'((IRQ_PULSE_FLOOR < 1) ? 1 : IRQ_PULSE_FLOOR);
    localparam int FIFO_W = 8;
    localparam int FIFO_DEPTH = 4;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WR = 3'b010,
        ST_RD = 3'b100
    } bus_state_e;
endpackage : usbdc_pkg

//--- dma_fifo_if.sv
`timescale 1ns/1ps
interface dma_fifo_if #(parameter int W = 8);
    logic in_valid;
    logic [W-1:0] in_data;
    logic in_ready;
    logic out_valid;
    logic [W-1:0] out_data;
    logic out_ready;
    logic accept_en;
    logic flush;
    modport store (
        input in_valid, in_data, out_ready, accept_en, flush,
        output in_ready, out_valid, out_data
    );
    modport user (
        output in_valid, in_data, out_ready, accept_en, flush,
        input in_ready, out_valid, out_data
    );
endinterface : dma_fifo_if

//--- dma_fifo.sv
`timescale 1ns/1ps
module dma_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // queue ports
    dma_fifo_if.store q
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic ready_r;
    logic push;
    logic pop;

    assign push = q.in_valid && ready_r;
    assign pop = q.out_valid && q.out_ready;
    assign q.in_ready = ready_r;
    assign q.out_valid = (cnt_r != '0);
    assign q.out_data = mem_r[rp_r];

    always_comb begin
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        if (q.flush) begin
            cnt_nxt = '0;
        end
    end

    // ready is a flop fed from the next count, so the source sees full in the cycle the queue fills
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            wp_r <= '0;
            rp_r <= '0;
            ready_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            ready_r <= q.accept_en && (cnt_nxt != (AW+1)'(DEPTH));
            if (q.flush) begin
                wp_r <= '0;
                rp_r <= '0;
            end else begin
                if (push) begin
                    wp_r <= AW'(wp_r + 1'b1);
                end
                if (pop) begin
                    rp_r <= AW'(rp_r + 1'b1);
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_r[wp_r] <= q.in_data;
        end
    end

    fifo_bound_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        cnt_r <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule : dma_fifo

//--- usbdc_cfg_regs.sv
`timescale 1ns/1ps
// Function
// - an event latches only if its enable bit is already set
// - usb bus reset leaves the interrupt enable mask unchanged
// - enable mask written by C2, read by C3, two words, low first
// - bits 23..10 enable endpoints 14..1, bit 9 ctrl in, 8 ctrl out
// - bits 6..0 gate short, pseudo frame, frame, end, suspend, resume, reset
// - dma setup written by F0, read by F1, one word
// - usb bus reset clears the run bit, other setup bits kept
// - bit 15 set ends the transfer when the byte count hits zero
// - bit 14 set ends the transfer on a short out packet
// - bits 7..4 select the dma endpoint
// - bit 3 write one runs, zero stops; reads back run state
// - bits 1..0 select burst of 1, 4, 8 or 16 bytes
// - F2 writes the transfer length, F3 reads bytes remaining
// - writing run one reloads the remaining count from the length
// - usb bus reset leaves the programmed length unchanged
// - F6 resets the registers like the hardware reset, except the pin synchronisers, read data, dma output byte, irq pulse count and irq pin
// - pin is high in reset, then follows polarity; pulse mode gives one short pulse
module usbdc_cfg_regs (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // processor bus pins
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_a0,
    input wire logic [15:0] i_data,
    output logic [15:0] o_data,
    output logic o_data_oe,
    // device events, one-cycle pulses
    input wire logic [15:0] i_ep_events,
    input wire logic i_short_packet,
    input wire logic i_short_out,
    input wire logic i_pseudo_frame,
    input wire logic i_frame_start,
    input wire logic i_suspend,
    input wire logic i_resume,
    input wire logic i_bus_reset,
    // interrupt pin
    input wire logic i_irq_active_high,
    input wire logic i_irq_pulse_mode,
    input wire logic i_irq_clear,
    output logic [23:0] o_irq_latch,
    output logic o_device_irq_pin,
    // dma byte stream
    input wire logic i_dma_valid,
    input wire logic [7:0] i_dma_byte,
    output logic o_dma_ready,
    output logic o_dma_valid,
    output logic [7:0] o_dma_byte,
    input wire logic i_dma_ready,
    output logic [3:0] o_dma_endpoint_select,
    output logic [4:0] o_burst_bytes,
    output logic o_dma_run,
    output logic o_transfer_end
);
    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] cmd_words(input logic [7:0] c);
        unique case (c)
            usbdc_pkg::CMD_IEN_WR, usbdc_pkg::CMD_IEN_RD: cmd_words = 2'h2;
            usbdc_pkg::CMD_CFG_WR, usbdc_pkg::CMD_CFG_RD,
            usbdc_pkg::CMD_CNT_WR, usbdc_pkg::CMD_CNT_RD: cmd_words = 2'h1;
            default: cmd_words = 2'h0;
        endcase
    endfunction : cmd_words

    function automatic logic cmd_is_read(input logic [7:0] c);
        cmd_is_read = (c == usbdc_pkg::CMD_IEN_RD) ||
            (c == usbdc_pkg::CMD_CFG_RD) || (c == usbdc_pkg::CMD_CNT_RD);
    endfunction : cmd_is_read

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [19:0] s1_r;
    logic [19:0] s2_r;
    logic [19:0] s3_r;
    logic [19:0] lvl_r;
    logic [19:0] prev_r;
    logic wr_done;
    logic rd_start;
    logic rd_done;

    // a bit only moves once stages two and three agree
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_r <= usbdc_pkg::PIN_IDLE;
            s2_r <= usbdc_pkg::PIN_IDLE;
            s3_r <= usbdc_pkg::PIN_IDLE;
            lvl_r <= usbdc_pkg::PIN_IDLE;
            prev_r <= usbdc_pkg::PIN_IDLE;
        end else begin
            s1_r <= {i_a0, i_cs_n, i_rd_n, i_wr_n, i_data};
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= (s3_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
            prev_r <= lvl_r;
        end
    end

    // data and a0 are taken from the level before the strobe rose,
    // so they need only hold until the strobe edge itself
    assign wr_done = lvl_r[16] && !prev_r[16] && !prev_r[18];
    assign rd_start = !lvl_r[17] && prev_r[17] && !lvl_r[18];
    assign rd_done = lvl_r[17] && !prev_r[17] && !prev_r[18];

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    usbdc_pkg::bus_state_e state_r;
    logic [7:0] cmd_r;
    logic word_r;
    logic wr_data;
    logic soft_rst;
    logic last_word;

    assign soft_rst = wr_done && prev_r[19] &&
        (prev_r[7:0] == usbdc_pkg::CMD_SOFT_RST);
    assign wr_data = wr_done && !prev_r[19] && (state_r == usbdc_pkg::ST_WR);
    assign last_word = (2'(word_r) + 2'h1) >= cmd_words(cmd_r);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= usbdc_pkg::ST_IDLE;
            cmd_r <= 8'h00;
            word_r <= 1'b0;
        end else if (soft_rst) begin
            state_r <= usbdc_pkg::ST_IDLE;
            cmd_r <= 8'h00;
            word_r <= 1'b0;
        end else if (wr_done && prev_r[19]) begin
            cmd_r <= prev_r[7:0];
            word_r <= 1'b0;
            if (cmd_words(prev_r[7:0]) == 2'h0) begin
                state_r <= usbdc_pkg::ST_IDLE;
            end else if (cmd_is_read(prev_r[7:0])) begin
                state_r <= usbdc_pkg::ST_RD;
            end else begin
                state_r <= usbdc_pkg::ST_WR;
            end
        end else if (wr_data ||
                (rd_done && state_r == usbdc_pkg::ST_RD)) begin
            word_r <= !word_r;
            if (last_word) begin
                state_r <= usbdc_pkg::ST_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ien_r;
    logic [15:0] cfg_r;
    logic [15:0] prog_cnt_r;
    logic [15:0] remain_r;
    logic run_r;
    logic run_nxt;
    logic cfg_wr;
    logic reload;
    logic pop;
    logic tend_now;

    assign cfg_wr = wr_data && (cmd_r == usbdc_pkg::CMD_CFG_WR);
    assign reload = cfg_wr && prev_r[usbdc_pkg::BIT_DMA_RUN];

    // bus reset has no term here: the mask survives it
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ien_r <= usbdc_pkg::IEN_RST;
        end else if (soft_rst) begin
            ien_r <= usbdc_pkg::IEN_RST;
        end else if (wr_data && cmd_r == usbdc_pkg::CMD_IEN_WR) begin
            if (word_r) begin
                ien_r[31:16] <= prev_r[15:0];
            end else begin
                ien_r[15:0] <= prev_r[15:0];
            end
        end
    end

    // run is held apart so the stored copy of bit 3 stays zero
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_r <= usbdc_pkg::CFG_RST;
        end else if (soft_rst) begin
            cfg_r <= usbdc_pkg::CFG_RST;
        end else if (cfg_wr) begin
            cfg_r <= prev_r[15:0] & ~(16'h0001 << usbdc_pkg::BIT_DMA_RUN);
        end
    end

    always_comb begin
        run_nxt = run_r;
        if (tend_now) begin
            run_nxt = 1'b0;
        end
        if (cfg_wr) begin
            run_nxt = prev_r[usbdc_pkg::BIT_DMA_RUN];
        end
        if (i_bus_reset || soft_rst) begin
            run_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prog_cnt_r <= usbdc_pkg::CNT_RST;
        end else if (soft_rst) begin
            prog_cnt_r <= usbdc_pkg::CNT_RST;
        end else if (wr_data && cmd_r == usbdc_pkg::CMD_CNT_WR) begin
            prog_cnt_r <= prev_r[15:0];
        end
    end

    // the count stops at zero rather than wrapping
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            remain_r <= usbdc_pkg::CNT_RST;
        end else if (soft_rst) begin
            remain_r <= usbdc_pkg::CNT_RST;
        end else if (reload) begin
            remain_r <= prog_cnt_r;
        end else if (pop && remain_r != 16'h0000) begin
            remain_r <= remain_r - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // dma stream and transfer end
    // ------------------------------------------------------------
    dma_fifo_if #(.W(usbdc_pkg::FIFO_W)) fq ();

    dma_fifo #(
        .W(usbdc_pkg::FIFO_W),
        .DEPTH(usbdc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .q(fq.store)
    );

    assign fq.in_valid = i_dma_valid;
    assign fq.in_data = i_dma_byte;
    assign fq.accept_en = run_nxt;
    assign fq.flush = soft_rst;
    assign fq.out_ready = run_r && (!o_dma_valid || i_dma_ready);
    assign o_dma_ready = fq.in_ready;
    assign pop = fq.out_valid && fq.out_ready;

    assign tend_now = run_r && (
        (pop && remain_r == 16'h0001 &&
            cfg_r[usbdc_pkg::BIT_COUNT_ZERO_END]) ||
        (i_short_out && cfg_r[usbdc_pkg::BIT_SHORT_END_MODE]));

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dma_valid <= 1'b0;
            o_dma_byte <= 8'h00;
            o_transfer_end <= 1'b0;
            o_dma_run <= 1'b0;
            o_dma_endpoint_select <= 4'h0;
            o_burst_bytes <= 5'h01;
        end else begin
            if (pop) begin
                o_dma_valid <= 1'b1;
                o_dma_byte <= fq.out_data;
            end else if (i_dma_ready || soft_rst) begin
                o_dma_valid <= 1'b0;
            end
            o_transfer_end <= tend_now;
            o_dma_run <= run_nxt;
            o_dma_endpoint_select <=
                cfg_r[usbdc_pkg::EP_SEL_LSB +: 4];
            unique case (cfg_r[usbdc_pkg::BURST_LSB +: 2])
                2'h0: o_burst_bytes <= 5'h01;
                2'h1: o_burst_bytes <= 5'h04;
                2'h2: o_burst_bytes <= 5'h08;
                2'h3: o_burst_bytes <= 5'h10;
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupt latching and pin
    // ------------------------------------------------------------
    logic [23:0] events;
    logic [23:0] latch;
    logic pending_r;
    logic [2:0] pulse_cnt_r;
    logic pin_act;

    // bits 23..8 endpoints, 7 reserved, 6..0 bus events with transfer end at 3
    assign events = {i_ep_events, 1'b0, i_short_packet, i_pseudo_frame,
        i_frame_start, tend_now, i_suspend, i_resume, i_bus_reset};
    // the mask is sampled at the event; a later enable cannot revive it
    assign latch = events & ien_r[23:0];
    assign pin_act = i_irq_pulse_mode ? (pulse_cnt_r != 3'h0) : pending_r;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pending_r <= 1'b0;
            pulse_cnt_r <= 3'h0;
            o_irq_latch <= 24'h000000;
            o_device_irq_pin <= 1'b1;
        end else begin
            o_irq_latch <= soft_rst ? 24'h000000 : latch;
            if (soft_rst) begin
                pending_r <= 1'b0;
            end else if (|latch) begin
                pending_r <= 1'b1;
            end else if (i_irq_clear) begin
                pending_r <= 1'b0;
            end
            if (|latch && !soft_rst) begin
                pulse_cnt_r <= usbdc_pkg::IRQ_PULSE_CYC;
            end else if (pulse_cnt_r != 3'h0) begin
                pulse_cnt_r <= pulse_cnt_r - 3'h1;
            end
            o_device_irq_pin <= i_irq_active_high ? pin_act : !pin_act;
        end
    end

    // ------------------------------------------------------------
    // read data drive
    // ------------------------------------------------------------
    logic [15:0] rd_word;

    always_comb begin
        rd_word = 16'h0000;
        unique case (cmd_r)
            usbdc_pkg::CMD_IEN_RD: rd_word = word_r ? ien_r[31:16] : ien_r[15:0];
            usbdc_pkg::CMD_CFG_RD: rd_word =
                cfg_r | (16'(run_r) << usbdc_pkg::BIT_DMA_RUN);
            usbdc_pkg::CMD_CNT_RD: rd_word = remain_r;
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data <= 16'h0000;
            o_data_oe <= 1'b0;
        end else if (rd_start && state_r == usbdc_pkg::ST_RD &&
                !lvl_r[19]) begin
            o_data <= rd_word;
            o_data_oe <= 1'b1;
        end else if (lvl_r[17] || lvl_r[18]) begin
            o_data_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    latch_gated_a: assert property (
        (o_irq_latch & ~$past(ien_r[23:0])) == 24'h000000)
        else $error("event latched while disabled");
    mask_kept_a: assert property (
        i_bus_reset && !wr_data && !soft_rst |=> $stable(ien_r))
        else $error("bus reset changed enable mask");
    run_cleared_a: assert property (
        i_bus_reset |=> !run_r ##1 !o_dma_run)
        else $error("bus reset left dma running");
    zero_end_a: assert property (
        run_r && pop && remain_r == 16'h0001 &&
        cfg_r[usbdc_pkg::BIT_COUNT_ZERO_END] |=> o_transfer_end)
        else $error("no end at zero count");
    short_end_a: assert property (
        run_r && i_short_out && cfg_r[usbdc_pkg::BIT_SHORT_END_MODE]
        |=> o_transfer_end && !run_r)
        else $error("no end on short packet");
    count_reload_a: assert property (
        reload && !soft_rst |=> remain_r == $past(prog_cnt_r))
        else $error("count not reloaded");
    soft_reset_a: assert property (
        soft_rst |=> ien_r == usbdc_pkg::IEN_RST &&
        cfg_r == usbdc_pkg::CFG_RST && prog_cnt_r == usbdc_pkg::CNT_RST &&
        !run_r && state_r == usbdc_pkg::ST_IDLE)
        else $error("soft reset incomplete");
    pulse_len_a: assert property (
        i_irq_pulse_mode && i_irq_active_high && |latch && !soft_rst
        ##1 (i_irq_pulse_mode && i_irq_active_high && latch == 24'h0)[*4]
        |-> o_device_irq_pin && $past(o_device_irq_pin) &&
        $past(o_device_irq_pin, 2) ##1 !o_device_irq_pin)
        else $error("irq pulse width wrong");
    run_read_a: assert property (
        rd_start && state_r == usbdc_pkg::ST_RD && !lvl_r[19] &&
        cmd_r == usbdc_pkg::CMD_CFG_RD
        |=> o_data[usbdc_pkg::BIT_DMA_RUN] == $past(run_r) && o_data_oe)
        else $error("run bit read back wrong");

    end_seen_c: cover property (o_transfer_end);
    soft_rst_c: cover property (soft_rst);
    full_fifo_c: cover property (run_r && !o_dma_ready && i_dma_valid);
    pulse_seen_c: cover property (i_irq_pulse_mode && |latch);
endmodule : usbdc_cfg_regs

//--- cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
    // clock and read data
    input wire logic i_clock,
    input wire logic [15:0] i_rdata,
    // processor bus pins
    output logic o_cs_n = 1'h1,
    output logic o_rd_n = 1'h1,
    output logic o_wr_n = 1'h1,
    output logic o_a0 = 1'h0,
    output logic [15:0] o_data = 16'h0000
);
    task automatic hold(input int n);
        repeat (n) @(posedge i_clock);
    endtask : hold
    // strobes held well past the three-flop synchroniser
    task automatic wr(input logic a, input logic [15:0] d);
        o_cs_n <= 1'h0;
        o_a0 <= a;
        o_data <= d;
        o_wr_n <= 1'h0;
        hold(5);
        o_wr_n <= 1'h1;
        hold(2);
        o_cs_n <= 1'h1;
        hold(6);
    endtask : wr
    task automatic rd(output logic [15:0] d);
        o_cs_n <= 1'h0;
        o_a0 <= 1'h0;
        // bus not driven by us: show a changing pattern
        o_data <= ~o_data;
        o_rd_n <= 1'h0;
        hold(8);
        d = i_rdata;
        o_rd_n <= 1'h1;
        hold(2);
        o_cs_n <= 1'h1;
        hold(6);
    endtask : rd
endmodule : cpu_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic i_clock = 1'h0;
    logic i_rst_n = 1'h0;
    logic cs_n, rd_n, wr_n, a0, oe, pin, ov, rdy, run, tend;
    logic ahi = 1'h1, pmode = 1'h0, clr = 1'h0, sho = 1'h0;
    logic dv = 1'h0, dr = 1'h0, full = 1'h0;
    logic [6:0] ev = '0;
    logic [15:0] ep = '0, wd, rdat;
    logic [7:0] db = '0, ob;
    logic [23:0] latch;
    logic [3:0] eps;
    logic [4:0] bb;
    logic [7:0] q[$];
    int fails = 0, n_compared = 0, n_end = 0;
    always #25 i_clock = ~i_clock;
    always @(posedge i_clock) if (tend === 1'h1) n_end++;
    cpu_model cpu (.i_clock(i_clock), .i_rdata(rdat), .o_cs_n(cs_n),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_a0(a0), .o_data(wd));
    usbdc_cfg_regs DUT (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_a0(a0),
        .i_data(wd), .o_data(rdat), .o_data_oe(oe), .i_ep_events(ep),
        .i_short_packet(ev[6]), .i_short_out(sho),
        .i_pseudo_frame(ev[5]), .i_frame_start(ev[4]),
        .i_suspend(ev[2]), .i_resume(ev[1]), .i_bus_reset(ev[0]),
        .i_irq_active_high(ahi), .i_irq_pulse_mode(pmode),
        .i_irq_clear(clr), .o_irq_latch(latch), .o_device_irq_pin(pin),
        .i_dma_valid(dv), .i_dma_byte(db), .o_dma_ready(rdy),
        .o_dma_valid(ov), .o_dma_byte(ob), .i_dma_ready(dr),
        .o_dma_endpoint_select(eps), .o_burst_bytes(bb),
        .o_dma_run(run), .o_transfer_end(tend));
    function automatic logic [4:0] burst_of(logic [1:0] c);
        return (c == 2'h0) ? 5'h01 : 5'h02 << c;
    endfunction : burst_of
    function automatic logic [23:0] lat_of(logic [31:0] m,
        logic [6:0] e, logic [15:0] p);
        return {p & m[23:8], 1'h0, e & m[6:0]};
    endfunction : lat_of
    task automatic check(string what, logic [31:0] seen, logic [31:0] x);
        n_compared++;
        if (seen !== x) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, x, seen);
        end
    endtask : check
    task automatic put(logic [7:0] c, logic [31:0] v, int n);
        cpu.wr(1'h1, {8'h00, c});
        for (int i = 0; i < n; i++) cpu.wr(1'h0, v[16*i +: 16]);
    endtask : put
    task automatic get(logic [7:0] c, int n, output logic [31:0] v);
        logic [15:0] w;
        v = '0;
        cpu.wr(1'h1, {8'h00, c});
        for (int i = 0; i < n; i++) begin
            cpu.rd(w);
            v[16*i +: 16] = w;
        end
    endtask : get
    task automatic rst_vals();
        logic [31:0] v;
        get(usbdc_pkg::CMD_IEN_RD, 2, v);
        check("mask", v, usbdc_pkg::IEN_RST);
        get(usbdc_pkg::CMD_CFG_RD, 1, v);
        check("setup", v, 32'(usbdc_pkg::CFG_RST));
        get(usbdc_pkg::CMD_CNT_RD, 1, v);
        check("count", v, 32'(usbdc_pkg::CNT_RST));
    endtask : rst_vals
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial begin
        #(50 * 30000);
        fails++;
        conclude();
    end
    initial begin
        logic [31:0] v, m;
        logic [15:0] s, p;
        logic [6:0] e7;
        int e, got, cnt;
        void'($urandom(32'h2FD69D53));
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'h1;
        @(posedge i_clock);
        rst_vals();
        // reserved top byte left zero; frame-start kept on for the pin test
        m = ($urandom() & 32'h00FF_FF6F) | 32'h0000_0010;
        put(usbdc_pkg::CMD_IEN_WR, m, 2);
        get(usbdc_pkg::CMD_IEN_RD, 2, v);
        check("mask", v, m);
        for (int k = 0; k < 8; k++) begin
            e7 = (k == 7) ? 7'h01 : 7'($urandom()) & 7'h76;
            p = 16'($urandom());
            ev <= e7;
            ep <= p;
            @(posedge i_clock);
            ev <= '0;
            ep <= '0;
            @(negedge i_clock);
            check("latch", latch, lat_of(m, e7, p));
            @(posedge i_clock);
        end
        get(usbdc_pkg::CMD_IEN_RD, 2, v);
        check("mask", v, m);
        pmode <= 1'h1;
        clr <= 1'h1;
        @(posedge i_clock);
        clr <= 1'h0;
        repeat (3) @(posedge i_clock);
        ev <= 7'h10;
        @(posedge i_clock);
        ev <= '0;
        cnt = 0;
        repeat (12) @(negedge i_clock) cnt += int'(pin === 1'h1);
        check("pulse", cnt, usbdc_pkg::IRQ_PULSE_CYC);
        for (int b = 0; b < 4; b++) begin
            put(usbdc_pkg::CMD_CFG_WR, 32'(b), 1);
            check("burst", bb, burst_of(2'(b)));
        end
        put(usbdc_pkg::CMD_CNT_WR, 32'h6, 1);
        // in-direction use: short mode left clear
        s = {4'h8, 4'h0, 4'($urandom()), 2'h2, 2'($urandom())};
        put(usbdc_pkg::CMD_CFG_WR, s, 1);
        check("endpoint", eps, s[7:4]);
        get(usbdc_pkg::CMD_CFG_RD, 1, v);
        check("setup", v, s);
        get(usbdc_pkg::CMD_CNT_RD, 1, v);
        check("count", v, 32'h6);
        e = n_end;
        fork
            begin
                for (int i = 0; i < 6; i++) begin
                    db <= 8'($urandom());
                    dv <= 1'h1;
                    @(negedge i_clock);
                    while (rdy !== 1'h1) begin
                        full = 1'h1;
                        @(negedge i_clock);
                    end
                    @(posedge i_clock);
                    q.push_back(db);
                end
                dv <= 1'h0;
            end
            begin
                got = 0;
                repeat (20) @(posedge i_clock);
                while (got < 6) begin
                    dr <= 1'($urandom());
                    @(negedge i_clock);
                    if (ov === 1'h1 && dr === 1'h1) begin
                        check("byte", ob, q.pop_front());
                        got++;
                    end
                    @(posedge i_clock);
                end
                dr <= 1'h0;
            end
        join
        repeat (3) @(posedge i_clock);
        check("refused", full, 1);
        check("ends", n_end - e, 1);
        check("run", run, 0);
        get(usbdc_pkg::CMD_CNT_RD, 1, v);
        check("count", v, 0);
        put(usbdc_pkg::CMD_CFG_WR, s, 1);
        get(usbdc_pkg::CMD_CNT_RD, 1, v);
        check("count", v, 32'h6);
        ev <= 7'h01;
        @(posedge i_clock);
        ev <= '0;
        repeat (2) @(posedge i_clock);
        check("run", run, 0);
        get(usbdc_pkg::CMD_CFG_RD, 1, v);
        check("setup", v, s & 16'hFFF7);
        put(usbdc_pkg::CMD_CFG_WR, s | 16'h4000, 1);
        get(usbdc_pkg::CMD_CNT_RD, 1, v);
        check("count", v, 32'h6);
        e = n_end;
        sho <= 1'h1;
        @(posedge i_clock);
        sho <= 1'h0;
        repeat (3) @(posedge i_clock);
        check("ends", n_end - e, 1);
        check("run", run, 0);
        put(usbdc_pkg::CMD_SOFT_RST, 0, 0);
        rst_vals();
        conclude();
    end
endmodule : tb_top
